// File: verilog/rsc_pkg.sv
package rsc_pkg;

  // Command words and command-field layouts
  localparam logic [2:0] CMD_REG_RD_TOP = 3'h0;
  localparam logic [2:0] CMD_REG_WR_TOP = 3'h1;
  localparam logic [7:0] CMD_RX_READ = 8'h61;
  localparam logic [7:0] CMD_TX_WRITE = 8'hA0;
  localparam logic [7:0] CMD_TX_FLUSH = 8'hE1;
  localparam logic [7:0] CMD_RX_FLUSH = 8'hE2;
  localparam logic [7:0] CMD_RESEND = 8'hE3;
  localparam logic [7:0] CMD_WIDTH = 8'h60;
  localparam logic [4:0] CMD_ACK_WR_TOP = 5'h15;
  localparam logic [7:0] CMD_NOACK_WR = 8'hB0;
  localparam logic [7:0] CMD_NOP = 8'hFF;
  localparam int CMD_TOP3_LSB = 5;
  localparam int CMD_TOP5_LSB = 3;
  localparam int ADDR_W = 5;
  localparam int PIPE_W = 3;
  localparam logic [2:0] PIPE_LAST = 3'h5;

  // Byte and entry counts
  localparam logic [5:0] PAYLOAD_MAX = 6'h20;
  localparam logic [5:0] WIDTH_BYTES = 6'h01;
  localparam logic [2:0] REG_BYTES_MAX = 3'h5;
  localparam int QUEUE_DEPTH = 3;

  // Status byte: pipe number field position
  localparam int STAT_PIPE_LSB = 1;
  localparam int STAT_PIPE_MSB = 3;

  // Pin vector positions of the synchronised link inputs
  localparam int PIN_MOSI = 0;
  localparam int PIN_SCK = 1;
  localparam int PIN_CSN = 2;
  localparam int PIN_CNT = 3;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CMD = 2'b01,
    ST_DATA = 2'b10
  } rsc_state_t;

  typedef enum logic [3:0] {
    OP_NONE = 4'b0000,
    OP_REG_RD = 4'b0001,
    OP_REG_WR = 4'b0010,
    OP_RX_RD = 4'b0011,
    OP_TX_WR = 4'b0100,
    OP_TX_FLUSH = 4'b0101,
    OP_RX_FLUSH = 4'b0110,
    OP_RESEND = 4'b0111,
    OP_WIDTH = 4'b1000,
    OP_ACK_WR = 4'b1001,
    OP_NOACK_WR = 4'b1010,
    OP_NOP = 4'b1011
  } rsc_op_t;

  typedef enum logic [1:0] {
    KIND_TX = 2'b00,
    KIND_NOACK = 2'b01,
    KIND_ACK = 2'b10
  } rsc_kind_t;

  typedef struct packed {
    rsc_kind_t kind;
    logic [2:0] pipe;
    logic [5:0] len;
  } rsc_commit_t;

endpackage

// File: verilog/rsc_cmd_decoder.sv
`timescale 1ns/1ps
// What this block does
// - Chip select fall starts a fresh command
// - Status byte shifts out during command byte
// - Command MSB first, data bytes low first
// - Multi-byte data: low byte first, MSB first
// - Register read returns 1 to 5 bytes
// - Register write stores bytes at 5-bit address
// - Payload read returns bytes, then pops entry
// - Payload write queues 1 to 32 bytes
// - Transmit flush empties the transmit queue
// - Receive flush empties the receive queue
// - Resend command marks last payload for reuse
// - Reuse holds until transmit payload write or transmit flush
// - Width query returns one head-entry byte
// - Acknowledge payload queued for pipes 0 to 5
// - Three pending acknowledge payloads, FIFO per pipe
// - No-acknowledge payload write in transmit role
// - No-op command only returns status
// - Feature commands need their enable bits
// - Short register write keeps upper bytes
// - Pipe field updates on interrupt falling edge
// - Queues hold three entries of 32 bytes
// - Interrupt line low-active, three maskable sources
module rsc_cmd_decoder
  import rsc_pkg::*;
#(
  parameter int SYNC_STAGES = 3
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Serial link pins
  input wire logic csn_b_i,
  input wire logic sck_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic miso_oe_o,
  // Status sources
  input wire logic [7:0] status_i,
  input wire logic irq_b_i,
  input wire logic [2:0] rx_pipe_i,
  // Feature enables
  input wire logic feat_dyn_width_i,
  input wire logic feat_ack_pay_i,
  input wire logic feat_noack_i,
  // Register map access
  output logic [4:0] reg_addr_o,
  output logic reg_wr_o,
  input wire logic [7:0] reg_rdata_i,
  input wire logic [2:0] reg_width_i,
  // Shared write byte and indexes
  output logic [7:0] wr_data_o,
  output logic [5:0] wr_idx_o,
  output logic [5:0] rd_idx_o,
  // Transmit queue
  output logic tx_byte_wr_o,
  output logic tx_commit_o,
  output rsc_commit_t tx_commit_info_o,
  output logic tx_flush_o,
  output logic reuse_active_o,
  input wire logic tx_full_i,
  // Receive queue
  input wire logic [7:0] rx_rdata_i,
  input wire logic [7:0] rx_width_i,
  input wire logic rx_empty_i,
  output logic rx_pop_o,
  output logic rx_flush_o
);

  function automatic rsc_op_t decode_cmd(input logic [7:0] c, input logic dyn,
                                         input logic ack, input logic noack,
                                         input logic full);
    rsc_op_t o;
    o = OP_NONE;
    if (c[7:CMD_TOP3_LSB] == CMD_REG_RD_TOP) begin
      o = OP_REG_RD;
    end else if (c[7:CMD_TOP3_LSB] == CMD_REG_WR_TOP) begin
      o = OP_REG_WR;
    end else if (c == CMD_RX_READ) begin
      o = OP_RX_RD;
    end else if (c == CMD_TX_WRITE) begin
      o = full ? OP_NONE : OP_TX_WR;
    end else if (c == CMD_TX_FLUSH) begin
      o = OP_TX_FLUSH;
    end else if (c == CMD_RX_FLUSH) begin
      o = OP_RX_FLUSH;
    end else if (c == CMD_RESEND) begin
      o = OP_RESEND;
    end else if (c == CMD_WIDTH) begin
      o = dyn ? OP_WIDTH : OP_NONE;
    end else if (c[7:CMD_TOP5_LSB] == CMD_ACK_WR_TOP) begin
      o = (ack && !full && c[2:0] <= PIPE_LAST) ? OP_ACK_WR : OP_NONE;
    end else if (c == CMD_NOACK_WR) begin
      o = (noack && !full) ? OP_NOACK_WR : OP_NONE;
    end else if (c == CMD_NOP) begin
      o = OP_NOP;
    end
    return o;
  endfunction

  function automatic logic [5:0] max_len(input rsc_op_t o, input logic [2:0] w);
    logic [5:0] n;
    n = 6'h00;
    case (o)
      OP_REG_RD, OP_REG_WR: begin
        n = {3'h0, (w > REG_BYTES_MAX) ? REG_BYTES_MAX : w};
      end
      OP_RX_RD, OP_TX_WR, OP_ACK_WR, OP_NOACK_WR: begin
        n = PAYLOAD_MAX;
      end
      OP_WIDTH: begin
        n = WIDTH_BYTES;
      end
      default: begin
        n = 6'h00;
      end
    endcase
    return n;
  endfunction

  // Three-stage sampling of the link pins
  logic [PIN_CNT-1:0] pin_raw;
  logic [SYNC_STAGES-1:0] sync_q [PIN_CNT];
  logic [PIN_CNT-1:0] pin_f;
  logic [PIN_CNT-1:0] pin_prev;

  assign pin_raw = {csn_b_i, sck_i, mosi_i};

  genvar gi;
  generate
    for (gi = 0; gi < PIN_CNT; gi++) begin : g_sync
      // Reset to the idle level (select high, clock and data low): no false edge after reset
      localparam logic IDLE_LVL = (gi == PIN_CSN);
      always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
          sync_q[gi] <= {SYNC_STAGES{IDLE_LVL}};
          pin_f[gi] <= IDLE_LVL;
          pin_prev[gi] <= IDLE_LVL;
        end else begin
          sync_q[gi] <= {sync_q[gi][SYNC_STAGES-2:0], pin_raw[gi]};
          pin_prev[gi] <= pin_f[gi];
          if (sync_q[gi][SYNC_STAGES-1] == sync_q[gi][SYNC_STAGES-2]) begin
            pin_f[gi] <= sync_q[gi][SYNC_STAGES-1];
          end
        end
      end
    end
  endgenerate

  wire csn_fall = pin_prev[PIN_CSN] && !pin_f[PIN_CSN];
  wire csn_rise = !pin_prev[PIN_CSN] && pin_f[PIN_CSN];
  wire sck_rise = !pin_prev[PIN_SCK] && pin_f[PIN_SCK];
  wire sck_fall = pin_prev[PIN_SCK] && !pin_f[PIN_SCK];
  wire mosi_bit = pin_f[PIN_MOSI];

  // Sequencer state
  rsc_state_t state;
  rsc_op_t op;
  logic [2:0] bit_cnt;
  logic [5:0] byte_cnt;
  logic [6:0] rx_sh;
  logic [7:0] tx_sh;
  logic load_pend;
  logic [2:0] pipe_q;
  logic irq_prev;
  logic [2:0] ack_pipe;

  wire active = (state != ST_IDLE) && !csn_fall && !csn_rise;
  wire byte_done = active && sck_rise && (bit_cnt == 3'h7);
  wire [7:0] byte_in = {rx_sh, mosi_bit};
  wire cmd_done = byte_done && (state == ST_CMD);
  wire data_done = byte_done && (state == ST_DATA);
  wire rsc_op_t dec_op = decode_cmd(byte_in, feat_dyn_width_i, feat_ack_pay_i,
                                    feat_noack_i, tx_full_i);
  wire [5:0] cur_max = max_len(op, reg_width_i);
  wire in_range = byte_cnt < cur_max;
  wire is_payload_wr = (op == OP_TX_WR) || (op == OP_ACK_WR) || (op == OP_NOACK_WR);
  wire [7:0] status_byte = {status_i[7:STAT_PIPE_MSB+1], pipe_q,
                            status_i[STAT_PIPE_LSB-1:0]};

  // Byte returned in the next data slot
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (in_range) begin
      case (op)
        OP_REG_RD: rd_byte = reg_rdata_i;
        OP_RX_RD: rd_byte = rx_rdata_i;
        OP_WIDTH: rd_byte = rx_width_i;
        default: rd_byte = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      state <= ST_IDLE;
    end else if (csn_fall) begin
      state <= ST_CMD;
    end else if (csn_rise) begin
      state <= ST_IDLE;
    end else if (cmd_done) begin
      state <= ST_DATA;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      bit_cnt <= 3'h0;
      rx_sh <= 7'h00;
    end else if (csn_fall) begin
      bit_cnt <= 3'h0;
    end else if (active && sck_rise) begin
      bit_cnt <= bit_cnt + 3'h1;
      rx_sh <= byte_in[6:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      op <= OP_NONE;
      reg_addr_o <= 5'h00;
      ack_pipe <= 3'h0;
      byte_cnt <= 6'h00;
    end else if (csn_fall) begin
      op <= OP_NONE;
      byte_cnt <= 6'h00;
    end else if (cmd_done) begin
      op <= dec_op;
      reg_addr_o <= byte_in[ADDR_W-1:0];
      ack_pipe <= byte_in[PIPE_W-1:0];
      byte_cnt <= 6'h00;
    end else if (data_done && in_range) begin
      byte_cnt <= byte_cnt + 6'h01;
    end
  end

  // MISO: status during command, then data, MSB first
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      tx_sh <= 8'h00;
      load_pend <= 1'h0;
    end else if (csn_fall) begin
      tx_sh <= status_byte;
      load_pend <= 1'h0;
    end else if (byte_done) begin
      load_pend <= 1'h1;
    end else if (active && sck_fall) begin
      tx_sh <= load_pend ? rd_byte : {tx_sh[6:0], 1'h0};
      load_pend <= 1'h0;
    end
  end

  assign miso_o = tx_sh[7];
  assign miso_oe_o = !pin_f[PIN_CSN];
  assign rd_idx_o = byte_cnt;

  // Write strobes for each register-write or payload-write data byte inside the command's length
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      reg_wr_o <= 1'h0;
      tx_byte_wr_o <= 1'h0;
      wr_data_o <= 8'h00;
      wr_idx_o <= 6'h00;
    end else begin
      reg_wr_o <= data_done && in_range && (op == OP_REG_WR);
      tx_byte_wr_o <= data_done && in_range && is_payload_wr;
      if (data_done && in_range) begin
        wr_data_o <= byte_in;
        wr_idx_o <= byte_cnt;
      end
    end
  end

  // Queue effects: flushes at command byte, payloads at chip select rise
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      tx_flush_o <= 1'h0;
      rx_flush_o <= 1'h0;
      tx_commit_o <= 1'h0;
      rx_pop_o <= 1'h0;
      tx_commit_info_o <= '0;
    end else begin
      tx_flush_o <= cmd_done && (dec_op == OP_TX_FLUSH);
      rx_flush_o <= cmd_done && (dec_op == OP_RX_FLUSH);
      tx_commit_o <= csn_rise && (state == ST_DATA) && is_payload_wr
                     && (byte_cnt != 6'h00);
      rx_pop_o <= csn_rise && (state == ST_DATA) && (op == OP_RX_RD)
                  && (byte_cnt != 6'h00) && !rx_empty_i;
      if (csn_rise) begin
        tx_commit_info_o.kind <= (op == OP_ACK_WR) ? KIND_ACK :
                                 (op == OP_NOACK_WR) ? KIND_NOACK : KIND_TX;
        tx_commit_info_o.pipe <= ack_pipe;
        tx_commit_info_o.len <= byte_cnt;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      reuse_active_o <= 1'h0;
    end else if (cmd_done && (dec_op == OP_TX_WR || dec_op == OP_TX_FLUSH)) begin
      reuse_active_o <= 1'h0;
    end else if (cmd_done && dec_op == OP_RESEND) begin
      reuse_active_o <= 1'h1;
    end
  end

  // Pipe field of the status byte, caught when the interrupt line falls
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      irq_prev <= 1'h1;
      pipe_q <= 3'h7;
    end else begin
      irq_prev <= irq_b_i;
      if (irq_prev && !irq_b_i) begin
        pipe_q <= rx_pipe_i;
      end
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  sequence seq_cmd(rsc_op_t o);
    cmd_done && (dec_op == o);
  endsequence

  sequence seq_frame_start;
    csn_fall;
  endsequence

  chk_frame_restart: assert property (seq_frame_start |=> state == ST_CMD
    && bit_cnt == 3'h0 && byte_cnt == 6'h00)
    else $error("chip select fall did not restart the command");
  chk_status_out: assert property (seq_frame_start |=>
    miso_o == $past(status_byte[7]) && tx_sh == $past(status_byte))
    else $error("status byte not presented on chip select fall");
  chk_reg_write: assert property (data_done && in_range && op == OP_REG_WR |=>
    reg_wr_o && wr_data_o == $past(byte_in) && wr_idx_o == $past(byte_cnt))
    else $error("register byte write lost or misplaced");
  chk_extra_bytes: assert property (data_done && !in_range |=>
    !reg_wr_o && !tx_byte_wr_o && $stable(byte_cnt))
    else $error("byte beyond command length took effect");
  chk_commit_edge: assert property ((tx_commit_o || rx_pop_o) |->
    $past(csn_rise) && tx_commit_info_o.len != 6'h00)
    else $error("queue change without chip select rise");
  chk_flush_pulse: assert property (seq_cmd(OP_TX_FLUSH) |=> tx_flush_o ##1 !tx_flush_o)
    else $error("transmit flush not a single pulse");
  chk_rx_flush: assert property (seq_cmd(OP_RX_FLUSH) |=> rx_flush_o && !tx_flush_o)
    else $error("receive flush missing");
  chk_reuse_hold: assert property (reuse_active_o && !(cmd_done && dec_op == OP_TX_WR)
    && !(cmd_done && dec_op == OP_TX_FLUSH) |=> reuse_active_o)
    else $error("reuse dropped without write or flush");
  chk_feature_gate: assert property (cmd_done && byte_in == CMD_WIDTH
    && !feat_dyn_width_i |=> op == OP_NONE)
    else $error("width query accepted while disabled");
  chk_pipe_capture: assert property (irq_prev && !irq_b_i |=>
    pipe_q == $past(rx_pipe_i))
    else $error("pipe field not caught on interrupt fall");

endmodule

// File: testbench/rsc_host_model.sv
`timescale 1ns/1ps
module rsc_host_model (
  // Clock
  input wire logic clk_i,
  // Link pins
  input wire logic miso_i,
  output logic csn_b_o,
  output logic sck_o,
  output logic mosi_o
);
  initial begin
    csn_b_o = 1'b1;
    sck_o = 1'b0;
    mosi_o = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic open_frame();
    wait_clk(1);
    csn_b_o = 1'b0;
    wait_clk(10);
  endtask
  // Mode 0: data set while the clock is low, both sides sample on its rise
  task automatic xfer(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      mosi_o = b[i];
      wait_clk(10);
      sck_o = 1'b1;
      r[i] = miso_i;
      wait_clk(10);
      sck_o = 1'b0;
    end
  endtask
  // Released data line shows the inverse of its last bit
  task automatic close_frame();
    wait_clk(10);
    csn_b_o = 1'b1;
    mosi_o = ~mosi_o;
    wait_clk(12);
  endtask
endmodule

// File: testbench/rsc_cmd_decoder_tb.sv
`timescale 1ns/1ps
module rsc_cmd_decoder_tb;
  import rsc_pkg::*;
  logic clk_i, rst_b_i, csn_b, sck, mosi, miso, miso_oe, irq_b, reg_wr;
  logic tx_bw, tx_cm, tx_fl, reuse, rx_pop, rx_fl, f_w, f_a, f_n, tx_full, rx_empty;
  logic [2:0] pipe;
  logic [4:0] reg_addr;
  logic [5:0] wr_idx, rd_idx;
  logic [7:0] wr_data, st;
  logic [7:0] td [4];
  logic [7:0] rd [4];
  logic [7:0] wbuf [5];
  logic [7:0] pcmd [5] = '{CMD_TX_WRITE, CMD_NOACK_WR, 8'hAC, 8'hAD, 8'hAE};
  rsc_kind_t pkind [4] = '{KIND_TX, KIND_NOACK, KIND_ACK, KIND_ACK};
  rsc_commit_t ci, last_ci;
  int n_rw, n_tb, n_cm, n_tf, n_rf, n_pop, n_oe, errors, checks_done;

  rsc_cmd_decoder dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .csn_b_i(csn_b), .sck_i(sck), .mosi_i(mosi),
    .miso_o(miso), .miso_oe_o(miso_oe), .status_i(8'hA5), .irq_b_i(irq_b),
    .rx_pipe_i(pipe), .feat_dyn_width_i(f_w), .feat_ack_pay_i(f_a), .feat_noack_i(f_n),
    .reg_addr_o(reg_addr), .reg_wr_o(reg_wr), .reg_rdata_i({reg_addr[3:0], rd_idx[3:0]}),
    .reg_width_i(3'h3), .wr_data_o(wr_data), .wr_idx_o(wr_idx), .rd_idx_o(rd_idx),
    .tx_byte_wr_o(tx_bw), .tx_commit_o(tx_cm), .tx_commit_info_o(ci), .tx_flush_o(tx_fl),
    .reuse_active_o(reuse), .tx_full_i(tx_full), .rx_rdata_i({2'b11, rd_idx}),
    .rx_width_i(8'h17), .rx_empty_i(rx_empty), .rx_pop_o(rx_pop), .rx_flush_o(rx_fl)
  );
  rsc_host_model host (.clk_i(clk_i), .miso_i(miso), .csn_b_o(csn_b), .sck_o(sck),
    .mosi_o(mosi));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // Pulse counters and a small register-map store
  always @(posedge clk_i) begin
    n_rw += int'(reg_wr === 1'b1);
    n_tb += int'(tx_bw === 1'b1);
    n_cm += int'(tx_cm === 1'b1);
    n_tf += int'(tx_fl === 1'b1);
    n_rf += int'(rx_fl === 1'b1);
    n_pop += int'(rx_pop === 1'b1);
    n_oe += int'(miso_oe === 1'b1);
    if (reg_wr === 1'b1) wbuf[wr_idx[2:0]] = wr_data;
    if (tx_cm === 1'b1) last_ci = ci;
  end

  task automatic chk_v(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_c(input string nm, input int e, input int g);
    checks_done++;
    if (g != e) begin
      errors++;
      $display("mismatch %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic run(input logic [7:0] cmd, input int n);
    {n_rw, n_tb, n_cm, n_tf, n_rf, n_pop, n_oe} = '0;
    host.open_frame();
    host.xfer(cmd, st);
    for (int k = 0; k < n; k++) host.xfer(td[k], rd[k]);
    host.close_frame();
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge clk_i);
    errors++;
    report_and_stop();
  end

  initial begin
    rst_b_i = 1'b0;
    irq_b = 1'b1;
    pipe = 3'h0;
    f_w = 1'b1;
    f_a = 1'b1;
    f_n = 1'b1;
    tx_full = 1'h0;
    rx_empty = 1'h0;
    errors = 0;
    checks_done = 0;
    td = '{8'h11, 8'h22, 8'h33, 8'h44};
    foreach (wbuf[i]) wbuf[i] = 8'hEE;
    repeat (3) @(negedge clk_i);
    rst_b_i = 1'b1;
    repeat (6) @(negedge clk_i);
    run(CMD_NOP, 0);
    chk_v("status", 16'h00AF, st);
    chk_c("side effects", 0, n_rw + n_tb + n_cm + n_tf + n_rf + n_pop);
    chk_v("miso drive", 16'h0000, miso_oe);
    chk_c("miso drive cycles", 180, n_oe);
    pipe = 3'h6;
    irq_b = 1'b0;
    repeat (3) @(negedge clk_i);
    irq_b = 1'b1;
    run(CMD_NOP, 0);
    chk_v("pipe field", 16'h00AD, st);
    run({CMD_REG_RD_TOP, 5'h0A}, 4);
    chk_v("status", 16'h00AD, st);
    chk_v("read addr", 16'h000A, reg_addr);
    for (int k = 0; k < 3; k++) chk_v("read byte", {12'h00A, k[3:0]}, rd[k]);
    chk_v("past width", 16'h0000, rd[3]);
    run({CMD_REG_WR_TOP, 5'h05}, 2);
    chk_v("write addr", 16'h0005, reg_addr);
    chk_c("write strobes", 2, n_rw);
    chk_v("byte 0", 16'h0011, wbuf[0]);
    chk_v("byte 1", 16'h0022, wbuf[1]);
    chk_v("byte 2", 16'h00EE, wbuf[2]);
    run({CMD_REG_WR_TOP, 5'h05}, 4);
    chk_c("write strobes", 3, n_rw);
    for (int i = 0; i < 5; i++) begin
      run(pcmd[i], 2);
      chk_c("commits", int'(i < 4), n_cm);
      chk_c("byte writes", (i < 4) ? 2 : 0, n_tb);
      if (i < 4) begin
        chk_v("kind len", {8'h0, pkind[i], 6'h02}, {8'h0, last_ci.kind, last_ci.len});
        if (i > 1) chk_v("pipe", {13'h0, pcmd[i][2:0]}, {13'h0, last_ci.pipe});
      end
    end
    tx_full = 1'h1;
    run(CMD_TX_WRITE, 1);
    chk_c("full commit", 0, n_cm);
    chk_c("full byte writes", 0, n_tb);
    tx_full = 1'h0;
    f_w = 1'b0;
    f_a = 1'b0;
    f_n = 1'b0;
    run(CMD_NOACK_WR, 1);
    chk_c("gated commit", 0, n_cm);
    run(8'hA8, 1);
    chk_c("gated commit", 0, n_cm);
    run(CMD_WIDTH, 1);
    chk_v("gated width", 16'h0000, rd[0]);
    f_w = 1'b1;
    run(CMD_WIDTH, 2);
    chk_v("width", 16'h0017, rd[0]);
    chk_v("width tail", 16'h0000, rd[1]);
    run(CMD_RESEND, 0);
    chk_v("reuse", 16'h0001, reuse);
    run(CMD_NOP, 0);
    chk_v("reuse held", 16'h0001, reuse);
    run(CMD_TX_WRITE, 1);
    chk_v("reuse end", 16'h0000, reuse);
    run(CMD_RESEND, 0);
    run(CMD_TX_FLUSH, 0);
    chk_v("reuse end", 16'h0000, reuse);
    chk_c("tx flush", 1, n_tf);
    run(CMD_RX_FLUSH, 0);
    chk_c("rx flush", 1, n_rf);
    rx_empty = 1'h1;
    run(CMD_RX_READ, 1);
    chk_c("empty pop", 0, n_pop);
    rx_empty = 1'h0;
    run(CMD_RX_READ, 3);
    for (int k = 0; k < 3; k++) chk_v("rx byte", {10'h003, k[5:0]}, rd[k]);
    chk_c("rx pop", 1, n_pop);
    run(CMD_RESEND, 0);
    chk_v("reuse", 16'h0001, reuse);
    @(negedge clk_i);
    rst_b_i = 1'h0;
    repeat (3) @(negedge clk_i);
    rst_b_i = 1'h1;
    repeat (6) @(negedge clk_i);
    chk_v("reuse after reset", 16'h0000, reuse);
    run(CMD_NOP, 0);
    chk_v("status after reset", 16'h00AF, st);
    report_and_stop();
  end
endmodule
